// File: psd_sequence_decoder.sv
// Sequence decoder: DMA fetch of duty words and load routing into the wave counter
`timescale 1ns/1ns
`include "psd_defines.svh"
module psd_sequence_decoder #(
   parameter int unsigned LEN_W = 15,
   parameter int unsigned CNT_W = 16
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output psd_pkg::psd_dma_req_t dma_req,
   input wire psd_pkg::psd_dma_rsp_t dma_rsp,
   input wire logic period_end,
   output psd_pkg::psd_load_bus_t cmp_load,
   output logic running,
   output logic [3:0] idle_level,
   output logic [6:0] event_pulse
);
   initial begin
      if (LEN_W < 2 || LEN_W > 31 || CNT_W < 1 || CNT_W > 31) begin
         $error("psd_sequence_decoder: unsupported width parameter");
      end
   end

   typedef struct packed {
      psd_pkg::psd_state_t st;
      logic [1:0] load_mode;
      logic stepped;
      logic [CNT_W-1:0] chain_repeat_count;
      logic [14:0] top_reg;
      logic [3:0] idle_reg;
      logic [1:0][31:0] ptr_reg;
      logic [1:0][LEN_W-1:0] len_reg;
      logic [1:0][CNT_W-1:0] refresh_reg;
      logic [1:0][CNT_W-1:0] delay_reg;
      logic [6:0] sticky;
      logic seq;
      logic [31:0] cur_ptr;
      logic [LEN_W-1:0] cur_len;
      logic [LEN_W-1:0] offs;
      logic [CNT_W-1:0] refresh;
      logic [CNT_W-1:0] delay;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] loops_left;
      logic looping;
      logic [1:0] word_idx;
      logic req;
      logic staged;
      logic last_staged;
      logic first;
      logic stop_pend;
      logic step_pend;
      psd_pkg::psd_load_bus_t stage;
      psd_pkg::psd_load_bus_t load;
      logic running;
      logic [3:0] idle_out;
      logic [6:0] ev;
      logic [31:0] rd_data;
   } psd_state_all_t;

   psd_state_all_t q;
   psd_state_all_t next_q;
   logic wr_stb;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic rd_stb;
   logic [11:0] rd_addr;
   logic wr_ok;
   logic rd_ok;
   logic [31:0] rd_word;

   // Index of the last word of one update for a routing mode
   function automatic logic [1:0] psd_words_last(input logic [1:0] mode);
      case (psd_pkg::psd_load_t'(mode))
         psd_pkg::PSD_LOAD_COMMON: psd_words_last = 2'd0;
         psd_pkg::PSD_LOAD_GROUPED: psd_words_last = 2'd1;
         default: psd_words_last = 2'd3;
      endcase
   endfunction

   // Register decoder shared by reads and writes
   function automatic logic psd_mapped(input logic [11:0] a);
      psd_mapped = (a[1:0] == 2'b00) && (a <= `PSD_OFF_DELAY1);
   endfunction

   psd_axil_slave u_axil (
      .core_clk(core_clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_stb(wr_stb),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_stb(rd_stb),
      .rd_addr(rd_addr),
      .rd_data(rd_word),
      .rd_ok(rd_ok)
   );
   assign wr_ok = psd_mapped(wr_addr);
   assign rd_ok = psd_mapped(rd_addr);

   // Read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      if (rd_addr == `PSD_OFF_DECODER) begin
         rd_word = {29'h0000_0000, q.stepped, q.load_mode};
      end else if (rd_addr == `PSD_OFF_LOOP) begin
         rd_word = 32'(q.chain_repeat_count);
      end else if (rd_addr == `PSD_OFF_TOP) begin
         rd_word = {17'h0_0000, q.top_reg};
      end else if (rd_addr == `PSD_OFF_IDLE) begin
         rd_word = {28'h000_0000, q.idle_reg};
      end else if (rd_addr == `PSD_OFF_EVENTS) begin
         rd_word = {25'h000_0000, q.sticky};
      end else if (rd_addr == `PSD_OFF_STATUS) begin
         rd_word = {24'h00_0000, 1'b0, 3'(q.st), q.seq, q.looping, q.stop_pend, q.running};
      end else if (rd_addr == `PSD_OFF_PTR0 || rd_addr == `PSD_OFF_PTR1) begin
         rd_word = q.ptr_reg[rd_addr[4]];
      end else if (rd_addr == `PSD_OFF_LEN0 || rd_addr == `PSD_OFF_LEN1) begin
         rd_word = 32'(q.len_reg[rd_addr[4]]);
      end else if (rd_addr == `PSD_OFF_REFRESH0 || rd_addr == `PSD_OFF_REFRESH1) begin
         rd_word = 32'(q.refresh_reg[rd_addr[4]]);
      end else if (rd_addr == `PSD_OFF_DELAY0 || rd_addr == `PSD_OFF_DELAY1) begin
         rd_word = 32'(q.delay_reg[rd_addr[4]]);
      end
   end

   // Sequencer, register writes and event logic
   always_comb begin
      logic [1:0] wl;
      logic start;
      logic start_seq;
      logic stop_task;
      logic adv_task;
      logic [LEN_W-1:0] bytes_left;
      logic apply;
      logic [6:0] clr;
      wl = psd_words_last(q.load_mode);
      start = 1'b0;
      start_seq = 1'b0;
      stop_task = 1'b0;
      adv_task = 1'b0;
      apply = 1'b0;
      clr = 7'h00;
      next_q = q;
      next_q.ev = 7'h00;
      next_q.load.load = 1'b0;
      next_q.rd_data = rd_word;
      bytes_left = q.cur_len - q.offs;
      // Register writes, full words only; pointer and length take effect at the next start or chain
      if (wr_stb && wr_strb == 4'hF) begin
         if (wr_addr == `PSD_OFF_TASK) begin
            start = wr_data[`PSD_TASK_START0] | wr_data[`PSD_TASK_START1];
            start_seq = wr_data[`PSD_TASK_START1] & ~wr_data[`PSD_TASK_START0];
            stop_task = wr_data[`PSD_TASK_STOP];
            adv_task = wr_data[`PSD_TASK_ADVANCE];
         end else if (wr_addr == `PSD_OFF_DECODER) begin
            next_q.load_mode = wr_data[1:0];
            next_q.stepped = wr_data[2];
         end else if (wr_addr == `PSD_OFF_LOOP) begin
            next_q.chain_repeat_count = wr_data[CNT_W-1:0];
         end else if (wr_addr == `PSD_OFF_TOP) begin
            next_q.top_reg = wr_data[14:0];
         end else if (wr_addr == `PSD_OFF_IDLE) begin
            next_q.idle_reg = wr_data[3:0];
         end else if (wr_addr == `PSD_OFF_EVENTS) begin
            clr = wr_data[6:0];
         end else if (wr_addr == `PSD_OFF_PTR0 || wr_addr == `PSD_OFF_PTR1) begin
            next_q.ptr_reg[wr_addr[4]] = wr_data;
         end else if (wr_addr == `PSD_OFF_LEN0 || wr_addr == `PSD_OFF_LEN1) begin
            next_q.len_reg[wr_addr[4]] = wr_data[LEN_W-1:0];
         end else if (wr_addr == `PSD_OFF_REFRESH0 || wr_addr == `PSD_OFF_REFRESH1) begin
            next_q.refresh_reg[wr_addr[4]] = wr_data[CNT_W-1:0];
         end else if (wr_addr == `PSD_OFF_DELAY0 || wr_addr == `PSD_OFF_DELAY1) begin
            next_q.delay_reg[wr_addr[4]] = wr_data[CNT_W-1:0];
         end
      end
      if (adv_task) begin
         next_q.step_pend = 1'b1;
      end
      // Stop is taken in any state, finishes at period end, or at once when not running
      if (stop_task) begin
         next_q.st = psd_pkg::PSD_STOPPING;
         next_q.req = 1'b0;
         next_q.stop_pend = 1'b1;
         if (!q.running) begin
            next_q.st = psd_pkg::PSD_IDLE;
            next_q.ev[`PSD_EV_HALTED] = 1'b1;
            next_q.stop_pend = 1'b0;
         end
      end else if (start) begin
         // Pointer, length and timing are sampled here
         next_q.seq = start_seq;
         next_q.cur_ptr = q.ptr_reg[start_seq];
         next_q.cur_len = q.len_reg[start_seq];
         next_q.refresh = q.refresh_reg[start_seq];
         next_q.delay = q.delay_reg[start_seq];
         next_q.offs = '0;
         next_q.word_idx = 2'd0;
         next_q.staged = 1'b0;
         next_q.first = 1'b1;
         next_q.looping = (q.chain_repeat_count != '0);
         next_q.loops_left = q.chain_repeat_count;
         next_q.req = 1'b1;
         next_q.st = psd_pkg::PSD_FETCH;
      end else begin
         case (q.st)
            psd_pkg::PSD_FETCH: begin
               // Gather the words of one update, then wait for period end; applied at once when not running
               if (q.req && dma_rsp.ack) begin
                  next_q.offs = q.offs + LEN_W'(2);
                  if (q.word_idx == 2'd3 && q.load_mode == 2'(psd_pkg::PSD_LOAD_PER_PERIOD_TOP)) begin
                     next_q.stage.top = dma_rsp.data[14:0];
                  end else begin
                     for (int c = 0; c < 4; c++) begin
                        if (q.load_mode == 2'(psd_pkg::PSD_LOAD_COMMON) ||
                            (q.load_mode == 2'(psd_pkg::PSD_LOAD_GROUPED) &&
                             c / 2 == int'(q.word_idx)) ||
                            (q.load_mode[1] && c == int'(q.word_idx))) begin
                           next_q.stage.cmp[c] = dma_rsp.data[14:0];
                           next_q.stage.pol[c] = dma_rsp.data[`PSD_POL_BIT];
                        end
                     end
                  end
                  if (q.word_idx == wl) begin
                     next_q.req = 1'b0;
                     next_q.word_idx = 2'd0;
                     next_q.staged = 1'b1;
                     next_q.last_staged = (bytes_left <= LEN_W'(2));
                     next_q.st = psd_pkg::PSD_WAIT_PERIOD;
                     if (!q.running) begin
                        apply = 1'b1;
                     end
                  end else begin
                     next_q.word_idx = q.word_idx + 2'd1;
                  end
               end
            end
            psd_pkg::PSD_WAIT_PERIOD: begin
               // Apply staged value at period end when the count allows, or when stepped, at period end after an advance task
               if (q.stepped) begin
                  apply = q.step_pend && period_end;
               end else if (period_end) begin
                  if (q.per_cnt >= q.refresh) begin
                     apply = 1'b1;
                  end else begin
                     next_q.per_cnt = q.per_cnt + CNT_W'(1);
                  end
               end
            end
            psd_pkg::PSD_HOLD: begin
               // Last value of the sequence executes for its refresh span
               if (period_end) begin
                  if (!q.stepped && q.per_cnt < q.refresh) begin
                     next_q.per_cnt = q.per_cnt + CNT_W'(1);
                  end else if (!q.stepped && q.delay != '0) begin
                     next_q.per_cnt = '0;
                     next_q.st = psd_pkg::PSD_DELAY;
                  end else begin
                     next_q.per_cnt = '0;
                     next_q.st = psd_pkg::PSD_DELAY;
                  end
               end
            end
            psd_pkg::PSD_DELAY: begin
               // Count end-delay periods, then chain or finish
               if (q.per_cnt >= q.delay || q.stepped || period_end) begin
                  if (q.per_cnt < q.delay && !q.stepped) begin
                     next_q.per_cnt = q.per_cnt + CNT_W'(1);
                  end else if (q.looping && (q.seq == 1'b0 || q.loops_left > CNT_W'(1))) begin
                     next_q.seq = ~q.seq;
                     if (q.seq) begin
                        next_q.loops_left = q.loops_left - CNT_W'(1);
                     end
                     next_q.cur_ptr = q.ptr_reg[~q.seq];
                     next_q.cur_len = q.len_reg[~q.seq];
                     next_q.refresh = q.refresh_reg[~q.seq];
                     next_q.delay = q.delay_reg[~q.seq];
                     next_q.offs = '0;
                     next_q.first = 1'b1;
                     next_q.req = 1'b1;
                     next_q.st = psd_pkg::PSD_FETCH;
                  end else begin
                     if (q.looping) begin
                        next_q.ev[`PSD_EV_REPEAT] = 1'b1;
                        next_q.st = psd_pkg::PSD_FETCH;
                        next_q.req = 1'b0;
                     end else begin
                        next_q.running = 1'b0;
                        next_q.st = psd_pkg::PSD_IDLE;
                     end
                  end
               end
            end
            psd_pkg::PSD_STOPPING: begin
               if (period_end) begin
                  next_q.running = 1'b0;
                  next_q.stop_pend = 1'b0;
                  next_q.ev[`PSD_EV_HALTED] = 1'b1;
                  next_q.st = psd_pkg::PSD_IDLE;
               end
            end
            default: begin
            end
         endcase
      end
      // Move staged value into the wave counter; a late fetch leaves the old one
      if (apply) begin
         next_q.load.cmp = next_q.stage.cmp;
         next_q.load.pol = next_q.stage.pol;
         next_q.load.top = (q.load_mode == 2'(psd_pkg::PSD_LOAD_PER_PERIOD_TOP)) ?
                           next_q.stage.top : q.top_reg;
         next_q.load.load = 1'b1;
         next_q.staged = 1'b0;
         next_q.running = 1'b1;
         next_q.per_cnt = '0;
         next_q.step_pend = 1'b0;
         next_q.refresh = q.refresh_reg[q.seq];
         next_q.delay = q.delay_reg[q.seq];
         next_q.ev[`PSD_EV_PERIOD] = q.running;
         if (q.first) begin
            next_q.first = 1'b0;
            next_q.ev[q.seq ? `PSD_EV_BEGAN1 : `PSD_EV_BEGAN0] = 1'b1;
         end
         if (next_q.last_staged) begin
            next_q.ev[q.seq ? `PSD_EV_FINISH1 : `PSD_EV_FINISH0] = 1'b1;
            next_q.st = psd_pkg::PSD_HOLD;
         end else begin
            next_q.req = 1'b1;
            next_q.st = psd_pkg::PSD_FETCH;
         end
      end else if (period_end && q.running && !next_q.load.load) begin
         next_q.load.top = (q.load_mode == 2'(psd_pkg::PSD_LOAD_PER_PERIOD_TOP)) ?
                           q.load.top : q.top_reg;
         next_q.ev[`PSD_EV_PERIOD] = 1'b1;
      end
      // Idle level drives pins when not generating
      next_q.idle_out = q.idle_reg;
      // Sticky flags: a new event wins over a clear
      next_q.sticky = (q.sticky & ~clr) | next_q.ev;
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         q <= '0;
         q.st <= psd_pkg::PSD_IDLE;
         q.top_reg <= `PSD_TOP_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign dma_req.addr = q.cur_ptr + 32'(q.offs);
   assign dma_req.req = q.req;
   assign cmp_load = q.load;
   assign running = q.running;
   assign idle_level = q.idle_out;
   assign event_pulse = q.ev;
endmodule

// File: psd_defines.svh
// Register offsets, field positions, reset values and AXI responses of the sequence decoder
`ifndef PSD_DEFINES_SVH
`define PSD_DEFINES_SVH
`define PSD_OFF_CTRL 12'h000
`define PSD_OFF_TASK 12'h004
`define PSD_OFF_DECODER 12'h008
`define PSD_OFF_LOOP 12'h00C
`define PSD_OFF_TOP 12'h010
`define PSD_OFF_IDLE 12'h014
`define PSD_OFF_EVENTS 12'h018
`define PSD_OFF_STATUS 12'h01C
`define PSD_OFF_PTR0 12'h020
`define PSD_OFF_LEN0 12'h024
`define PSD_OFF_REFRESH0 12'h028
`define PSD_OFF_DELAY0 12'h02C
`define PSD_OFF_PTR1 12'h030
`define PSD_OFF_LEN1 12'h034
`define PSD_OFF_REFRESH1 12'h038
`define PSD_OFF_DELAY1 12'h03C
`define PSD_TASK_START0 0
`define PSD_TASK_START1 1
`define PSD_TASK_STOP 2
`define PSD_TASK_ADVANCE 3
`define PSD_EV_HALTED 0
`define PSD_EV_BEGAN0 1
`define PSD_EV_BEGAN1 2
`define PSD_EV_FINISH0 3
`define PSD_EV_FINISH1 4
`define PSD_EV_PERIOD 5
`define PSD_EV_REPEAT 6
`define PSD_POL_BIT 15
`define PSD_TOP_RESET 15'h03E8
`define PSD_AXI_OKAY 2'b00
`define PSD_AXI_SLVERR 2'b10
`endif

// File: psd_pkg.sv
// Types shared by the sequence decoder files
package psd_pkg;
   typedef enum logic [1:0] {
      PSD_LOAD_COMMON,
      PSD_LOAD_GROUPED,
      PSD_LOAD_INDIVIDUAL,
      PSD_LOAD_PER_PERIOD_TOP
   } psd_load_t;
   typedef enum logic [2:0] {
      PSD_IDLE,
      PSD_FETCH,
      PSD_WAIT_PERIOD,
      PSD_HOLD,
      PSD_DELAY,
      PSD_STOPPING
   } psd_state_t;
   typedef struct packed {
      logic [31:0] addr;
      logic req;
   } psd_dma_req_t;
   typedef struct packed {
      logic [15:0] data;
      logic ack;
   } psd_dma_rsp_t;
   typedef struct packed {
      logic [3:0][14:0] cmp;
      logic [3:0] pol;
      logic [14:0] top;
      logic load;
   } psd_load_bus_t;
endpackage

// File: psd_axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ns
`include "psd_defines.svh"
module psd_axil_slave (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_stb,
   output logic [11:0] wr_addr,
   output logic [31:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_ok,
   output logic rd_stb,
   output logic [11:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_ok
);
   typedef struct packed {
      logic aw_have;
      logic w_have;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic wr_stb;
      logic rd_stb;
      logic [11:0] araddr;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } psd_axi_state_t;
   psd_axi_state_t q;
   psd_axi_state_t next_q;

   // Capture address and data in any order, strobe once both are held
   always_comb begin
      next_q = q;
      next_q.wr_stb = 1'b0;
      next_q.rd_stb = 1'b0;
      if (s_axi_awvalid && !q.aw_have && !q.bvalid) begin
         next_q.aw_have = 1'b1;
         next_q.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_have && !q.bvalid) begin
         next_q.w_have = 1'b1;
         next_q.wdata = s_axi_wdata;
         next_q.wstrb = s_axi_wstrb;
      end
      if (q.aw_have && q.w_have && !q.bvalid && !q.wr_stb) begin
         next_q.wr_stb = 1'b1;
      end
      if (q.wr_stb) begin
         next_q.bvalid = 1'b1;
         next_q.bresp = wr_ok ? `PSD_AXI_OKAY : `PSD_AXI_SLVERR;
         next_q.aw_have = 1'b0;
         next_q.w_have = 1'b0;
      end
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid && !q.rd_stb) begin
         next_q.araddr = s_axi_araddr;
         next_q.rd_stb = 1'b1;
      end
      if (q.rd_stb) begin
         next_q.rvalid = 1'b1;
         next_q.rdata = rd_ok ? rd_data : 32'h0000_0000;
         next_q.rresp = rd_ok ? `PSD_AXI_OKAY : `PSD_AXI_SLVERR;
      end
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Readies are combinational so a source is taken in its valid cycle
   assign s_axi_awready = !q.aw_have && !q.bvalid;
   assign s_axi_wready = !q.w_have && !q.bvalid;
   assign s_axi_arready = !q.rvalid && !q.rd_stb;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign wr_stb = q.wr_stb;
   assign wr_addr = q.awaddr;
   assign wr_data = q.wdata;
   assign wr_strb = q.wstrb;
   assign rd_stb = q.rd_stb;
   assign rd_addr = q.araddr;
endmodule

// File: psd_seq_chk_sva.sv
// Checker of the sequence decoder ports
`timescale 1ns/1ns
module psd_seq_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire psd_pkg::psd_dma_req_t dma_req,
   input wire psd_pkg::psd_dma_rsp_t dma_rsp,
   input wire logic running,
   input wire logic [6:0] event_pulse,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_event_pulse: assert property ((event_pulse & $past(event_pulse)) == 7'h00)
      else $error("event longer than one cycle");
   a_halt_idle: assert property (event_pulse[0] |=> !running)
      else $error("running after halt");
   a_began_run: assert property (event_pulse[1] |-> ##[0:1] running)
      else $error("began while idle");
   a_one_began: assert property (!(event_pulse[1] && event_pulse[2]))
      else $error("two sequences began");
   a_addr_hold: assert property (dma_req.req && !dma_rsp.ack |=> !dma_req.req || $stable(dma_req.addr))
      else $error("fetch address moved");
   a_addr_step: assert property (dma_req.req && dma_rsp.ack ##1 dma_req.req |-> dma_req.addr == $past(dma_req.addr) + 2)
      else $error("fetch step not two");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   // Main scenarios reached
   c_repeat: cover property (event_pulse[6]);
   c_halt: cover property (event_pulse[0]);
   c_fetch: cover property (dma_req.req && dma_rsp.ack);
endmodule
bind psd_sequence_decoder psd_seq_chk u_chk (.core_clk, .resetn, .dma_req, .dma_rsp, .running,
   .event_pulse, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: psd_ram_model.sv
// RAM behind the fetch port, prompt or slow
`timescale 1ns/1ns
module psd_ram_model (
   input wire logic core_clk,
   input wire logic resetn,
   input wire psd_pkg::psd_dma_req_t dma_req,
   output psd_pkg::psd_dma_rsp_t dma_rsp,
   input wire logic slow
);
   int w = 0;
   initial dma_rsp = '0;
   // Word depends on address; data line inverts while not answering
   always @(posedge core_clk) begin
      dma_rsp.ack <= 1'b0;
      dma_rsp.data <= ~dma_rsp.data;
      if (resetn && dma_req.req && !dma_rsp.ack) begin
         w <= (w < 3 * slow) ? w + 1 : 0;
         if (w >= 3 * slow) begin
            dma_rsp.ack <= 1'b1;
            dma_rsp.data <= dma_req.addr[15:0] ^ 16'h5a5a;
         end
      end
   end
endmodule

// File: tb_pwm_sequence_decoder.sv
// Testbench of the sequence decoder
`timescale 1ns/1ns
module tb_pwm_sequence_decoder;
   logic core_clk = 0, resetn = 0, period_end = 0, slow = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, p;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, running;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] idle_level;
   logic [6:0] event_pulse;
   logic [15:0] d;
   psd_pkg::psd_dma_req_t dma_req;
   psd_pkg::psd_dma_rsp_t dma_rsp;
   psd_pkg::psd_load_bus_t cmp_load;
   int seed = 32'h4dfc_b712, mismatches = 0, checked = 0, md, n, evn [7];
   logic [33:0] rq [$], rm [$], lq [$];
   psd_sequence_decoder dut (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .dma_req, .dma_rsp, .period_end, .cmp_load, .running,
      .idle_level, .event_pulse);
   psd_ram_model ram (.core_clk, .resetn, .dma_req, .dma_rsp, .slow);
   initial forever #5 core_clk = ~core_clk;
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [33:0] e, input logic [33:0] m);
      rq.push_back(e & m);
      rm.push_back(m);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask
   // Issue a task and wait, bounded, for the named event
   task automatic go(input logic [3:0] b, input int k);
      int t;
      int w;
      t = evn[k];
      wr(12'h004, {28'h000_0000, b});
      for (w = 0; evn[k] == t && w < 5000; w++) @(posedge core_clk);
      chk("event", 34'h1, 34'(evn[k] != t));
   endtask
   // Random period ends, event counts and result comparison
   always @(posedge core_clk) begin
      period_end <= resetn && !period_end && ($random(seed) % 16 == 0);
      for (int k = 0; k < 7; k++) if (event_pulse[k]) evn[k] <= evn[k] + 1;
      if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata} & rm.pop_front());
      if (cmp_load.load) chk("load", lq.pop_front(), md == 3 ? {1'b0, cmp_load.top} : {cmp_load.pol[3], cmp_load.cmp[3]});
   end
   initial begin
      #500000;
      mismatches++;
      give_verdict;
   end
   // One update per routing mode, then chained playback
   initial begin
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rd(12'h010, 34'h0_0000_03e8, '1);
      rd(12'h0fc, 34'h2_0000_0000, '1);
      for (md = 0; md < 4; md++) begin
         n = (md == 0) ? 1 : (md == 1) ? 2 : 4;
         p = 32'h0000_0100 * (md + 1);
         d = p[15:0] + 16'(2 * n - 2) ^ 16'h5a5a;
         lq.push_back(md == 3 ? {19'h0_0000, d[14:0]} : d);
         slow <= 1'($random(seed));
         wr(12'h008, md);
         wr(12'h020, p);
         wr(12'h024, 2 * n);
         wr(12'h028, 0);
         wr(12'h02c, 0);
         wr(12'h00c, 0);
         go(4'h1, 3);
         go(4'h4, 0);
      end
      rd(12'h018, 34'h0_0000_000b, 34'h3_0000_000b);
      wr(12'h014, 5);
      chk("idle", 34'h5, 34'(idle_level));
      // Task-stepped playback: second word waits for an advance task
      lq.push_back(16'h0200 ^ 16'h5a5a);
      lq.push_back(16'h0202 ^ 16'h5a5a);
      wr(12'h008, 4);
      wr(12'h020, 32'h0000_0200);
      wr(12'h024, 4);
      go(4'h1, 1);
      go(4'h8, 3);
      go(4'h4, 0);
      lq.push_back(16'h0200 ^ 16'h5a5a);
      lq.push_back(16'h0300 ^ 16'h5a5a);
      wr(12'h008, 0);
      wr(12'h00c, 1);
      wr(12'h020, 32'h0000_0200);
      wr(12'h024, 2);
      wr(12'h02c, 1);
      wr(12'h030, 32'h0000_0300);
      wr(12'h034, 2);
      wr(12'h038, 0);
      wr(12'h03c, 0);
      go(4'h1, 6);
      go(4'h4, 0);
      give_verdict;
   end
endmodule
